// ---- core/fan_lut_entry_two_params.svh ----
// offsets, field positions, reset values and masks for lookup entry two
`ifndef FAN_LUT_ENTRY_TWO_PARAMS_SVH
`define FAN_LUT_ENTRY_TWO_PARAMS_SVH
`define ADDR_LIMIT        8'h52
`define ADDR_DUTY         8'h53
`define RST_LIMIT         8'h7f
`define RST_DUTY          8'h3f
`define LIMIT_HALF_POS    7
`define DUTY_EXT_MASK     8'hc0
`define DUTY_BASE_MASK    8'h3f
`define LIMIT_WHOLE_MASK  8'h7f
`define WR_ENABLE_POS     5
`endif

// ---- core/fan_lut_entry_two_pkg.sv ----
// types shared by the lookup entry two block
package fan_lut_entry_two_pkg;
   typedef enum logic {below_limit, above_limit} entry_state_e;
   typedef logic [10:0] half_deg_t;
endpackage : fan_lut_entry_two_pkg

// ---- core/fan_lut_entry_two.sv ----
// lookup table entry two: limit/duty pair, compare and duty select
`timescale 1ns/10ps
`include "fan_lut_entry_two_params.svh"
module fan_lut_entry_two
   import fan_lut_entry_two_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic [7:0] lut_control,
   input  wire logic       temp_high_res,
   input  wire logic       duty_high_res,
   input  wire logic       pwm_freq_22k5,
   input  wire logic [7:0] lut_temp_offset,
   input  wire logic [4:0] table_hysteresis_degrees,
   input  wire logic [7:0] remote_temp_whole,
   input  wire logic       remote_temp_half,
   input  wire logic [7:0] lower_duty,
   output logic      [7:0] pwm_duty,
   output logic            entry2_active
);
   logic [7:0]   limit_reg;
   logic [7:0]   duty_reg;
   logic [7:0]   next_limit_reg;
   logic [7:0]   next_duty_reg;
   logic [7:0]   next_reg_rdata;
   logic [7:0]   limit_view;
   logic [7:0]   duty_view;
   entry_state_e state;
   entry_state_e next_state;
   logic [7:0]   next_pwm_duty;
   logic         next_entry2_active;
   half_deg_t    limit_units;
   half_deg_t    temp_units;
   half_deg_t    hyst_units;
   logic         wr_allowed;
   logic         entry2_limit_half_bit;
   logic [6:0]   entry2_limit_whole_bits;
   logic [1:0]   entry2_duty_extension;
   logic [5:0]   entry2_duty_base;
   logic [8:0]   limit_whole_sum;

   // host writes gated by table write enable; reads never gated
   assign wr_allowed = reg_wr & lut_control[`WR_ENABLE_POS];

   // mode-masked views: a stale high bit left from high mode never leaks
   assign limit_view = temp_high_res ? limit_reg
                     : (limit_reg & `LIMIT_WHOLE_MASK);
   assign duty_view  = duty_high_res ? duty_reg
                                     : (duty_reg & `DUTY_BASE_MASK);

   assign entry2_limit_half_bit   = limit_view[`LIMIT_HALF_POS];
   assign entry2_limit_whole_bits = limit_view[6:0];
   assign entry2_duty_extension   = duty_view[7:6];
   assign entry2_duty_base        = duty_view[5:0];

   // offset register lifts the limit beyond 127 degrees
   assign limit_whole_sum = {2'h0, entry2_limit_whole_bits}
                          + {1'h0, lut_temp_offset};

   // everything compared in half degree units; low mode half bits are zero
   assign limit_units = {1'h0, limit_whole_sum,
                         entry2_limit_half_bit};
   assign temp_units  = {2'h0, remote_temp_whole,
                         temp_high_res & remote_temp_half};
   assign hyst_units  = {5'h00, table_hysteresis_degrees, 1'h0};

   always_comb begin
      next_limit_reg = limit_reg;
      next_duty_reg  = duty_reg;
      if (wr_allowed && reg_addr == `ADDR_LIMIT) begin
         next_limit_reg = temp_high_res ? reg_wdata
                        : (reg_wdata & `LIMIT_WHOLE_MASK);
      end
      if (wr_allowed && reg_addr == `ADDR_DUTY) begin
         next_duty_reg = duty_high_res ? reg_wdata
                       : (reg_wdata & `DUTY_BASE_MASK);
      end
      case (reg_addr)
         `ADDR_LIMIT: next_reg_rdata = limit_view;
         `ADDR_DUTY:  next_reg_rdata = duty_view;
         default:     next_reg_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         limit_reg <= `RST_LIMIT;
         duty_reg  <= `RST_DUTY;
         reg_rdata <= 8'h00;
      end else begin
         limit_reg <= next_limit_reg;
         duty_reg  <= next_duty_reg;
         reg_rdata <= next_reg_rdata;
      end
   end

   // compare and duty selection
   always_comb begin
      next_state = state;
      case (state)
         below_limit: begin
            if (temp_units > limit_units) begin
               next_state = above_limit;
            end
         end
         above_limit: begin
            // fall back only once hysteresis below limit; sum avoids underflow
            if (temp_units + hyst_units <= limit_units) begin
               next_state = below_limit;
            end
         end
         default: next_state = below_limit;
      endcase
      next_pwm_duty = lower_duty;
      if (next_state == above_limit) begin
         if (duty_high_res && pwm_freq_22k5) begin
            next_pwm_duty = {entry2_duty_extension,
                             entry2_duty_base};
         end else begin
            next_pwm_duty = {2'h0, entry2_duty_base};
         end
      end
      next_entry2_active = (next_state == above_limit);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state         <= below_limit;
         pwm_duty      <= 8'h00;
         entry2_active <= 1'b0;
      end else begin
         state         <= next_state;
         pwm_duty      <= next_pwm_duty;
         entry2_active <= next_entry2_active;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   a_wr_gated: assert property (
      reg_wr && !lut_control[`WR_ENABLE_POS] |=> $stable(limit_reg)
         && $stable(duty_reg))
      else $error("write took effect while table writes disabled");
   a_limit_write: assert property (
      wr_allowed && reg_addr == `ADDR_LIMIT && temp_high_res
         |=> limit_reg == $past(reg_wdata))
      else $error("high mode limit write not stored whole");
   a_limit_low_top: assert property (
      !temp_high_res && reg_addr == `ADDR_LIMIT |=> reg_rdata[7] == 1'b0)
      else $error("low mode limit top bit read as one");
   a_duty_low_ext: assert property (
      !duty_high_res && reg_addr == `ADDR_DUTY |=> reg_rdata[7:6] == 2'h0)
      else $error("low mode duty extension read nonzero");
   a_rise_above: assert property (
      state == below_limit && temp_units > limit_units
         |=> entry2_active && state == above_limit)
      else $error("entry did not activate above limit");
   a_stay_below: assert property (
      state == below_limit && temp_units <= limit_units
         |=> !entry2_active)
      else $error("entry activated at or below limit");
   a_hyst_hold: assert property (
      state == above_limit && temp_units + hyst_units > limit_units
         |=> entry2_active)
      else $error("entry dropped inside hysteresis band");
   a_duty_ext: assert property (
      next_state == above_limit && !(duty_high_res && pwm_freq_22k5)
         |=> pwm_duty[7:6] == 2'h0 && pwm_duty[5:0] == $past(duty_reg[5:0]))
      else $error("extension bits used outside 22.5 kHz high mode");
   a_duty_high: assert property (
      next_state == above_limit && duty_high_res && pwm_freq_22k5
         |=> pwm_duty == $past(duty_reg))
      else $error("high mode duty not formed from all eight bits");
   a_duty_lower: assert property (
      next_state == below_limit |=> pwm_duty == $past(lower_duty))
      else $error("inactive entry did not pass lower duty");

   // register port: stored and read values per mode
   a_duty_write: assert property (
      wr_allowed && reg_addr == `ADDR_DUTY && duty_high_res
         |=> duty_reg == $past(reg_wdata))
      else $error("high mode duty write not stored whole");

   a_duty_low_wr: assert property (
      wr_allowed && reg_addr == `ADDR_DUTY && !duty_high_res
         |=> duty_reg == ($past(reg_wdata) & `DUTY_BASE_MASK))
      else $error("low mode duty write kept extension bits");

   a_limit_low_wr: assert property (
      wr_allowed && reg_addr == `ADDR_LIMIT && !temp_high_res
         |=> limit_reg == ($past(reg_wdata) & `LIMIT_WHOLE_MASK))
      else $error("low mode limit write kept top bit");

   a_other_wr: assert property (
      reg_wr && reg_addr != `ADDR_LIMIT && reg_addr != `ADDR_DUTY
         |=> $stable(limit_reg) && $stable(duty_reg))
      else $error("write to another address changed the entry");

   a_no_wr_hold: assert property (
      !reg_wr |=> $stable(limit_reg) && $stable(duty_reg))
      else $error("entry changed without a write");

   a_read_limit: assert property (
      reg_addr == `ADDR_LIMIT && temp_high_res
         |=> reg_rdata == $past(limit_reg))
      else $error("high mode limit read back wrong");

   a_read_limit_low: assert property (
      reg_addr == `ADDR_LIMIT && !temp_high_res
         |=> reg_rdata == {1'b0, $past(limit_reg[6:0])})
      else $error("low mode limit read back wrong");

   a_read_duty: assert property (
      reg_addr == `ADDR_DUTY && duty_high_res
         |=> reg_rdata == $past(duty_reg))
      else $error("high mode duty read back wrong");

   a_read_duty_low: assert property (
      reg_addr == `ADDR_DUTY && !duty_high_res
         |=> reg_rdata == {2'h0, $past(duty_reg[5:0])})
      else $error("low mode duty read back wrong");

   a_read_other: assert property (
      reg_addr != `ADDR_LIMIT && reg_addr != `ADDR_DUTY
         |=> reg_rdata == 8'h00)
      else $error("unmapped address read nonzero");

   // compare path checked against raw register and temperature fields
   a_low_activate: assert property (
      state == below_limit && !temp_high_res
         && {1'b0, remote_temp_whole}
            > {2'h0, limit_reg[6:0]} + {1'b0, lut_temp_offset}
         |=> entry2_active)
      else $error("low mode entry did not activate above limit");

   a_offset_hold: assert property (
      state == below_limit && !temp_high_res
         && {1'b0, remote_temp_whole}
            <= {2'h0, limit_reg[6:0]} + {1'b0, lut_temp_offset}
         |=> !entry2_active)
      else $error("offset limit not honoured in low mode");

   a_high_activate: assert property (
      state == below_limit && temp_high_res && lut_temp_offset == 8'h00
         && {remote_temp_whole, remote_temp_half}
            > {1'b0, limit_reg[6:0], limit_reg[7]}
         |=> entry2_active)
      else $error("high mode entry did not activate above limit");

   a_low_half_off: assert property (
      state == below_limit && !temp_high_res && lut_temp_offset == 8'h00
         && remote_temp_whole == {1'b0, limit_reg[6:0]}
         |=> !entry2_active)
      else $error("low mode half degree bit took part in compare");

   a_high_half_on: assert property (
      state == below_limit && temp_high_res && lut_temp_offset == 8'h00
         && remote_temp_whole == {1'b0, limit_reg[6:0]}
         && remote_temp_half && !limit_reg[7]
         |=> entry2_active)
      else $error("high mode half degree above limit not seen");

   a_zero_floor: assert property (
      state == below_limit && remote_temp_whole == 8'h00 && !remote_temp_half
         |=> !entry2_active)
      else $error("zero degrees treated as above a positive limit");

   a_high_ceiling: assert property (
      state == below_limit && temp_high_res && lut_temp_offset == 8'h00
         && remote_temp_whole[7] |=> entry2_active)
      else $error("high mode limit reached past 127.5 degrees");

   a_low_ceiling: assert property (
      state == below_limit && !temp_high_res && lut_temp_offset == 8'h00
         && remote_temp_whole[7] |=> entry2_active)
      else $error("low mode limit reached past 127 degrees");

   a_hyst_release: assert property (
      state == above_limit && temp_units + hyst_units <= limit_units
         |=> !entry2_active)
      else $error("entry held past the hysteresis band");

   a_low_duty_base: assert property (
      next_state == above_limit && !duty_high_res
         |=> pwm_duty == {2'h0, $past(duty_reg[5:0])})
      else $error("low duty mode used more than base bits");

   a_flag_state: assert property (
      entry2_active == (state == above_limit))
      else $error("active flag disagrees with compare state");

   // reset overrides the default disable so its effect is checked too
   a_reset_regs: assert property (disable iff (1'b0)
      srst |=> limit_reg == `RST_LIMIT && duty_reg == `RST_DUTY
         && reg_rdata == 8'h00)
      else $error("registers not at reset values after reset");

   a_reset_outs: assert property (disable iff (1'b0)
      srst |=> pwm_duty == 8'h00 && !entry2_active
         && state == below_limit)
      else $error("outputs not idle after reset");

   c_activate: cover property (!entry2_active ##1 entry2_active);
   c_release:  cover property (entry2_active ##1 !entry2_active);
   c_blocked:  cover property (reg_wr && !lut_control[`WR_ENABLE_POS]);
   c_hi_duty:  cover property (entry2_active && duty_high_res
                               && pwm_freq_22k5);
   c_hyst_band: cover property (state == above_limit && temp_units <= limit_units
                               && temp_units + hyst_units > limit_units);
endmodule : fan_lut_entry_two

// ---- tb/host_model.sv ----
// host side model: register writes and reads on the entry-two port
`timescale 1ns/10ps
module host_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic      [7:0] lut_control
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      lut_control = 8'h00;
   end
   // enable bit travels with each write so refusals are explicit
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic en);
      @(posedge clk_sys);
      lut_control <= {2'b00, en, 5'b00000};
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      @(posedge clk_sys);
      @(negedge clk_sys);
      d = reg_rdata;
   endtask : rd
endmodule : host_model

// ---- tb/tb.sv ----
// self-checking bench for lookup entry two
`timescale 1ns/10ps
module tb;
   typedef struct {logic [3:0] md; logic [7:0] lim, dty, ofs, tw;
                   logic ea; logic [7:0] ed, el;} row_s;
   // md = temp_high_res, duty_high_res, pwm_freq_22k5, remote_temp_half
   row_s rows [9] = '{
      '{4'b1111, 8'h85, 8'hc5, 8'h00, 8'h05, 1'b0, 8'h11, 8'h85},
      '{4'b1110, 8'h85, 8'hc5, 8'h00, 8'h06, 1'b1, 8'hc5, 8'h85},
      '{4'b0111, 8'h85, 8'hc5, 8'h00, 8'h05, 1'b0, 8'h11, 8'h05},
      '{4'b0100, 8'h85, 8'hc5, 8'h00, 8'h06, 1'b1, 8'h05, 8'h05},
      '{4'b0010, 8'h85, 8'hc5, 8'h00, 8'h06, 1'b1, 8'h05, 8'h05},
      '{4'b0000, 8'h7f, 8'hc5, 8'h10, 8'h8f, 1'b0, 8'h11, 8'h7f},
      '{4'b0000, 8'h7f, 8'hc5, 8'h10, 8'h90, 1'b1, 8'h05, 8'h7f},
      '{4'b1111, 8'hff, 8'h3a, 8'h00, 8'h7f, 1'b0, 8'h11, 8'hff},
      '{4'b1110, 8'hff, 8'h3a, 8'h00, 8'h80, 1'b1, 8'h3a, 8'hff}};
   logic       clk_sys = 1'b0;
   logic       srst = 1'b1;
   logic       thr = 1'b0, dhr = 1'b0, f22 = 1'b0, thalf = 1'b0;
   logic       wr, act;
   logic [4:0] hyst = 5'h00;
   logic [7:0] addr, wdata, rdata, ctrl, duty, rd_v;
   logic [7:0] off = 8'h00, twhole = 8'h00;
   int         err_total = 0, num_checks = 0, cyc = 0;
   always #50 clk_sys = ~clk_sys;
   host_model host_u (.clk_sys(clk_sys), .reg_rdata(rdata), .reg_addr(addr),
      .reg_wr(wr), .reg_wdata(wdata), .lut_control(ctrl));
   fan_lut_entry_two dut_u (.clk_sys(clk_sys), .srst(srst),
      .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata),
      .lut_control(ctrl), .temp_high_res(thr), .duty_high_res(dhr),
      .pwm_freq_22k5(f22), .lut_temp_offset(off),
      .table_hysteresis_degrees(hyst), .remote_temp_whole(twhole),
      .remote_temp_half(thalf), .lower_duty(8'h11), .pwm_duty(duty),
      .entry2_active(act));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   // generous ceiling: the whole run needs well under a thousand cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      host_u.rd(8'h52, rd_v);
      chk(rd_v, 8'h7f);
      host_u.rd(8'h53, rd_v);
      chk(rd_v, 8'h3f);
      foreach (rows[i]) begin
         @(posedge clk_sys);
         {thr, dhr, f22, thalf} <= rows[i].md;
         off <= rows[i].ofs;
         host_u.wr(8'h52, rows[i].lim, 1'b1);
         host_u.wr(8'h53, rows[i].dty, 1'b1);
         twhole <= rows[i].tw;
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         chk({7'h00, act}, {7'h00, rows[i].ea});
         chk(duty, rows[i].ed);
         host_u.rd(8'h52, rd_v);
         chk(rd_v, rows[i].el);
      end
      host_u.wr(8'h52, 8'h20, 1'b0);
      host_u.rd(8'h52, rd_v);
      chk(rd_v, 8'hff);
      host_u.rd(8'h40, rd_v);
      chk(rd_v, 8'h00);
      host_u.wr(8'h53, 8'h00, 1'b0);
      host_u.wr(8'h40, 8'h55, 1'b1);
      host_u.rd(8'h53, rd_v);
      chk(rd_v, 8'h3a);
      // hysteresis: 16 degree limit, 3 degrees back off
      @(posedge clk_sys);
      {thr, dhr, f22, thalf} <= 4'b0000;
      hyst <= 5'h03;
      host_u.wr(8'h52, 8'h10, 1'b1);
      twhole <= 8'h11;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({7'h00, act}, 8'h01);
      @(posedge clk_sys);
      twhole <= 8'h0e;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({7'h00, act}, 8'h01);
      @(posedge clk_sys);
      twhole <= 8'h0d;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({7'h00, act}, 8'h00);
      // mid-run reset: entry back to defaults, outputs idle
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({7'h00, act}, 8'h00);
      chk(duty, 8'h00);
      @(posedge clk_sys);
      srst <= 1'b0;
      host_u.rd(8'h52, rd_v);
      chk(rd_v, 8'h7f);
      chk(duty, 8'h11);
      tally_and_finish();
   end
endmodule : tb
